// File: rtl/paging_pkg.sv
package paging_pkg;

   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned EA_W       = 16;
   localparam int unsigned XADDR_W    = 24;
   localparam int unsigned NUM_WREGS  = 16;

   // register byte offsets
   localparam logic [7:0] OFS_READ_PAGE  = 8'h00;
   localparam logic [7:0] OFS_WRITE_PAGE = 8'h04;
   localparam logic [7:0] OFS_CONTROL    = 8'h08;
   localparam logic [7:0] OFS_XMOD_START = 8'h0C;
   localparam logic [7:0] OFS_XMOD_END   = 8'h10;
   localparam logic [7:0] OFS_YMOD_START = 8'h14;
   localparam logic [7:0] OFS_YMOD_END   = 8'h18;
   localparam logic [7:0] OFS_BREV_MOD   = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;

   // widths and reset values
   localparam int unsigned READ_PAGE_W  = 10;
   localparam int unsigned WRITE_PAGE_W = 9;
   localparam int unsigned CONTROL_W    = 3;
   localparam logic [9:0]  READ_PAGE_RST  = 10'h000;
   localparam logic [8:0]  WRITE_PAGE_RST = 9'h000;
   localparam logic [2:0]  CONTROL_RST    = 3'h0;
   localparam logic [15:0] MOD_START_RST  = 16'h0000;
   localparam logic [15:0] MOD_END_RST    = 16'hFFFF;
   localparam logic [15:0] BREV_MOD_RST   = 16'h0000;

   // field positions
   localparam int unsigned CTRL_XMOD_BIT  = 0;
   localparam int unsigned CTRL_YMOD_BIT  = 1;
   localparam int unsigned CTRL_BREV_BIT  = 2;
   localparam int unsigned PAGE_PSV_BIT   = 9;
   localparam int unsigned EA_UPPER_BIT   = 15;
   localparam logic [3:0]  SP_INDEX       = 4'hF;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      TGT_BASE,
      TGT_EDS,
      TGT_PSV
   } target_t;

endpackage

// File: rtl/agu_if.sv
`timescale 1ns/1ps
interface agu_if;
   logic [15:0] ptr;
   logic [15:0] modify;
   logic        mod_en;
   logic [15:0] mod_start;
   logic [15:0] mod_end;
   logic        brev_en;
   logic [15:0] brev_mod;
   logic [15:0] next_ptr;

   modport gen  (input ptr, modify, mod_en, mod_start, mod_end, brev_en, brev_mod,
                 output next_ptr);
   modport user (output ptr, modify, mod_en, mod_start, mod_end, brev_en, brev_mod,
                 input next_ptr);
endinterface

// File: rtl/address_generator.sv
`timescale 1ns/1ps
module address_generator
   import paging_pkg::*;
#(
   parameter bit BREV_OK = 1'b1
) (
   agu_if.gen agu
);
   logic [15:0] sum;
   logic [15:0] span;
   logic [15:0] ptr_rev;
   logic [15:0] mod_rev;
   logic [15:0] rev_sum;
   logic [15:0] brev_ptr;

   // bit-reversed stepping is a carry that runs from msb toward lsb
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_rev
         assign ptr_rev[i]  = agu.ptr[15-i];
         assign mod_rev[i]  = agu.brev_mod[15-i];
         assign brev_ptr[i] = rev_sum[15-i];
      end
   endgenerate

   assign rev_sum = ptr_rev + mod_rev;
   assign sum     = agu.ptr + agu.modify;
   assign span    = agu.mod_end - agu.mod_start + 16'h0001;

   always_comb begin
      agu.next_ptr = sum;
      if (BREV_OK && agu.brev_en) begin
         agu.next_ptr = brev_ptr;
      end else if (agu.mod_en) begin
         // circular buffer: a step that leaves the window folds back by its length
         if (!agu.modify[15] && (sum > agu.mod_end)) begin
            agu.next_ptr = sum - span;
         end else if (agu.modify[15] && (sum < agu.mod_start)) begin
            agu.next_ptr = sum + span;
         end
      end
   end
endmodule

// File: rtl/data_space_paging_agu.sv
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - base data space: 16-bit byte address, 64KB
// - upper 32KB maps through the read and write page registers
// - program space readable through upper window
// - 10-bit read page, 9-bit write page
// - paged read: page[8:0] above ea[14:0]
// - paged write: page[8:0] above ea[14:0]
// - extended space spans 24-bit byte addresses
// - post modify steps linearly across pages; a pre-modify that leaves the upper half accesses base space
// - general accesses use X generator only
// - dual operand fetch uses X and Y
// - modulo in X and Y, X for all
// - bit-reverse in X; none without DSP
// - sixteen working registers, last is stack pointer
module data_space_paging_agu
   import paging_pkg::*;
#(
   parameter bit DSP_EN = 1'b1
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  req_valid,
   input  wire logic                  req_write,
   input  wire logic                  req_dual,
   input  wire logic                  req_update,
   input  wire logic                  req_pre,
   input  wire logic [3:0]            x_sel,
   input  wire logic [3:0]            y_sel,
   input  wire logic [15:0]           x_modify,
   input  wire logic [15:0]           y_modify,
   input  wire logic                  wreg_we,
   input  wire logic [3:0]            wreg_sel,
   input  wire logic [15:0]           wreg_data,
   output logic                       acc_valid,
   output logic                       acc_write,
   output target_t                    acc_target,
   output logic [XADDR_W-1:0]         acc_addr,
   output logic                       y_acc_valid,
   output logic [EA_W-1:0]            y_acc_addr,
   output logic [15:0]                stack_pointer
);

   logic [9:0]  read_page_select_r;
   logic [8:0]  write_page_select_r;
   logic [2:0]  control_r;
   logic [15:0] xmod_start_r;
   logic [15:0] xmod_end_r;
   logic [15:0] ymod_start_r;
   logic [15:0] ymod_end_r;
   logic [15:0] brev_mod_r;
   logic [15:0] wreg_r [NUM_WREGS];

   // ---------------- register bus ----------------
   logic                  aw_held_r;
   logic [AXI_ADDR_W-1:0] aw_addr_r;
   logic                  w_held_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  rvalid_r;
   logic [31:0]           rdata_r;
   logic [1:0]            rresp_r;
   logic                  wr_commit;

   function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFS_STATUS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_commit     = aw_held_r && w_held_r && !bvalid_r;

   function automatic logic wr_hit(input logic [7:0] ofs);
      return wr_commit && (aw_addr_r == ofs);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_commit) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_commit) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_READ_PAGE:  rdata_r <= {22'h000000, read_page_select_r};
            OFS_WRITE_PAGE: rdata_r <= {23'h000000, write_page_select_r};
            OFS_CONTROL:    rdata_r <= {29'h00000000, control_r};
            OFS_XMOD_START: rdata_r <= {16'h0000, xmod_start_r};
            OFS_XMOD_END:   rdata_r <= {16'h0000, xmod_end_r};
            OFS_YMOD_START: rdata_r <= {16'h0000, ymod_start_r};
            OFS_YMOD_END:   rdata_r <= {16'h0000, ymod_end_r};
            OFS_BREV_MOD:   rdata_r <= {16'h0000, brev_mod_r};
            OFS_STATUS:     rdata_r <= {6'h00, acc_target, acc_addr};
            default:        rdata_r <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_r    <= CONTROL_RST;
         xmod_start_r <= MOD_START_RST;
         xmod_end_r   <= MOD_END_RST;
         ymod_start_r <= MOD_START_RST;
         ymod_end_r   <= MOD_END_RST;
         brev_mod_r   <= BREV_MOD_RST;
      end else begin
         // bits above each register width are dropped on purpose
         if (wr_hit(OFS_CONTROL)) begin
            control_r <= 3'(merge({29'h0, control_r}, w_data_r, w_strb_r));
         end
         if (wr_hit(OFS_XMOD_START)) begin
            xmod_start_r <= 16'(merge({16'h0, xmod_start_r}, w_data_r, w_strb_r));
         end
         if (wr_hit(OFS_XMOD_END)) begin
            xmod_end_r <= 16'(merge({16'h0, xmod_end_r}, w_data_r, w_strb_r));
         end
         if (wr_hit(OFS_YMOD_START)) begin
            ymod_start_r <= 16'(merge({16'h0, ymod_start_r}, w_data_r, w_strb_r));
         end
         if (wr_hit(OFS_YMOD_END)) begin
            ymod_end_r <= 16'(merge({16'h0, ymod_end_r}, w_data_r, w_strb_r));
         end
         if (wr_hit(OFS_BREV_MOD)) begin
            brev_mod_r <= 16'(merge({16'h0, brev_mod_r}, w_data_r, w_strb_r));
         end
      end
   end

   // ---------------- address generators ----------------
   agu_if x_agu ();
   agu_if y_agu ();
   logic [15:0] x_ptr;
   logic [15:0] y_ptr;
   logic [15:0] x_ea;
   logic [15:0] y_ea;
   logic        x_paged;
   logic        step_wrap;
   logic        step_down;
   logic [15:0] x_wb;

   assign x_ptr = wreg_r[x_sel];
   assign y_ptr = wreg_r[y_sel];

   // modulo on X for every class, Y too
   // bit-reverse only on X, both gone without DSP
   assign x_agu.ptr       = x_ptr;
   assign x_agu.modify    = x_modify;
   assign x_agu.mod_en    = DSP_EN && control_r[CTRL_XMOD_BIT];
   assign x_agu.mod_start = xmod_start_r;
   assign x_agu.mod_end   = xmod_end_r;
   assign x_agu.brev_en   = DSP_EN && control_r[CTRL_BREV_BIT];
   assign x_agu.brev_mod  = brev_mod_r;
   assign y_agu.ptr       = y_ptr;
   assign y_agu.modify    = y_modify;
   assign y_agu.mod_en    = DSP_EN && control_r[CTRL_YMOD_BIT];
   assign y_agu.mod_start = ymod_start_r;
   assign y_agu.mod_end   = ymod_end_r;
   assign y_agu.brev_en   = 1'b0;
   assign y_agu.brev_mod  = 16'h0000;

   address_generator #(.BREV_OK(1'b1)) u_x_gen (.agu(x_agu));
   address_generator #(.BREV_OK(1'b0)) u_y_gen (.agu(y_agu));

   assign x_ea = req_pre ? x_agu.next_ptr : x_ptr;
   assign y_ea = req_pre ? y_agu.next_ptr : y_ptr;

   // a paged pointer that steps out of the upper half carries into the page
   assign x_paged   = req_valid && x_ptr[EA_UPPER_BIT];
   assign step_wrap = x_paged && req_update && !x_agu.next_ptr[EA_UPPER_BIT];
   assign step_down = x_modify[15];
   assign x_wb      = step_wrap ? {1'b1, x_agu.next_ptr[14:0]} : x_agu.next_ptr;

   // page registers; a bus write wins over a stepping carry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_page_select_r <= READ_PAGE_RST;
      end else if (wr_hit(OFS_READ_PAGE)) begin
         read_page_select_r <= 10'(merge({22'h0, read_page_select_r}, w_data_r, w_strb_r));
      end else if (step_wrap && !req_write) begin
         read_page_select_r[8:0] <= step_down ? read_page_select_r[8:0] - 9'h001
                                              : read_page_select_r[8:0] + 9'h001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_page_select_r <= WRITE_PAGE_RST;
      end else if (wr_hit(OFS_WRITE_PAGE)) begin
         write_page_select_r <= 9'(merge({23'h0, write_page_select_r}, w_data_r, w_strb_r));
      end else if (step_wrap && req_write) begin
         write_page_select_r <= step_down ? write_page_select_r - 9'h001
                                          : write_page_select_r + 9'h001;
      end
   end

   // working registers; a direct core write wins over pointer writeback
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WREGS; gi++) begin : g_wreg
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               wreg_r[gi] <= 16'h0000;
            end else if (wreg_we && (wreg_sel == 4'(gi))) begin
               wreg_r[gi] <= wreg_data;
            end else if (req_valid && req_update && (x_sel == 4'(gi))) begin
               wreg_r[gi] <= x_wb;
            end else if (DSP_EN && req_valid && req_dual && req_update
                         && (y_sel == 4'(gi))) begin
               wreg_r[gi] <= y_agu.next_ptr;
            end
         end
      end
   endgenerate

   assign stack_pointer = wreg_r[SP_INDEX];

   // ---------------- address translation ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_valid  <= 1'b0;
         acc_write  <= 1'b0;
         acc_target <= TGT_BASE;
         acc_addr   <= 24'h000000;
      end else begin
         acc_valid <= req_valid;
         if (req_valid) begin
            acc_write <= req_write;
            if (!x_ea[EA_UPPER_BIT]) begin
               acc_target <= TGT_BASE;
               acc_addr   <= {8'h00, x_ea};
            end else if (req_write) begin
               acc_target <= TGT_EDS;
               acc_addr   <= {write_page_select_r[8:0], x_ea[14:0]};
            end else if (read_page_select_r[PAGE_PSV_BIT]) begin
               // page bit 9 selects the program view
               // 32KB window at a 32KB-aligned program boundary
               acc_target <= TGT_PSV;
               acc_addr   <= {read_page_select_r[8:0], x_ea[14:0]};
            end else begin
               acc_target <= TGT_EDS;
               acc_addr   <= {read_page_select_r[8:0], x_ea[14:0]};
            end
         end
      end
   end

   // dual fetch drives Y alongside X
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         y_acc_valid <= 1'b0;
         y_acc_addr  <= 16'h0000;
      end else begin
         y_acc_valid <= DSP_EN && req_valid && req_dual;
         if (DSP_EN && req_valid && req_dual) begin
            y_acc_addr <= y_ea;
         end
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_base_direct: assert property (
      req_valid && !x_ea[15] |=> acc_valid && acc_target == TGT_BASE
                                 && acc_addr == {8'h00, $past(x_ea)})
      else $error("base access not direct");

   a_eds_read: assert property (
      req_valid && !req_write && x_ea[15] && !read_page_select_r[9]
      |=> acc_target == TGT_EDS
          && acc_addr == {$past(read_page_select_r[8:0]), $past(x_ea[14:0])})
      else $error("paged read address wrong");

   a_eds_write: assert property (
      req_valid && req_write && x_ea[15]
      |=> acc_write && acc_addr == {$past(write_page_select_r), $past(x_ea[14:0])})
      else $error("paged write address wrong");

   a_psv_read: assert property (
      req_valid && !req_write && x_ea[15] && read_page_select_r[9] |=> acc_target == TGT_PSV)
      else $error("program view not selected");

   a_x_only: assert property (
      req_valid && !req_dual |=> !y_acc_valid)
      else $error("Y used by general access");

   a_dual_fetch: assert property (
      req_valid && req_dual |=> y_acc_valid == DSP_EN && acc_valid)
      else $error("dual fetch missing Y");

   a_sp_write: assert property (
      wreg_we && wreg_sel == SP_INDEX |=> stack_pointer == $past(wreg_data))
      else $error("stack pointer not written");

   a_page_width: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_READ_PAGE
      |=> s_axi_rvalid && s_axi_rdata[31:10] == 22'h000000)
      else $error("read page wider than 10 bits");

   a_page_step: assert property (
      step_wrap && !req_write && !step_down && !wr_hit(OFS_READ_PAGE)
      |=> read_page_select_r[8:0] == $past(read_page_select_r[8:0]) + 9'h001)
      else $error("page did not advance");
endmodule

// File: bench/core_model.sv
`timescale 1ns/1ps
module core_model (
   input  wire logic aclk,
   output logic      req_valid,
   output logic      req_write,
   output logic      req_dual,
   output logic      req_update,
   output logic      req_pre,
   output logic [3:0]  x_sel,
   output logic [3:0]  y_sel,
   output logic [15:0] x_modify,
   output logic [15:0] y_modify,
   output logic        wreg_we,
   output logic [3:0]  wreg_sel,
   output logic [15:0] wreg_data
);
   initial begin
      {req_valid, req_write, req_dual, req_update, req_pre} = 5'h00;
      {x_sel, y_sel, x_modify, y_modify} = 40'h0;
      {wreg_we, wreg_sel, wreg_data} = 21'h0;
   end

   task automatic set_wreg(input logic [3:0] s, input logic [15:0] d);
      @(posedge aclk);
      wreg_we   <= 1'b1;
      wreg_sel  <= s;
      wreg_data <= d;
      @(posedge aclk);
      wreg_we   <= 1'b0;
      wreg_data <= ~d;
   endtask

   // request stands for one edge; modify values scrambled after so stale values never help
   task automatic access(input logic w, dual, upd, pre, input logic [3:0] xs, ys,
                         input logic [15:0] xm, ym);
      @(posedge aclk);
      req_valid  <= 1'b1;
      req_write  <= w;
      req_dual   <= dual;
      req_update <= upd;
      req_pre    <= pre;
      {x_sel, y_sel, x_modify, y_modify} <= {xs, ys, xm, ym};
      @(posedge aclk);
      req_valid  <= 1'b0;
      req_update <= 1'b0;
      {x_modify, y_modify} <= ~{xm, ym};
      #1;
   endtask
endmodule

// File: bench/data_space_paging_agu_tb_top.sv
`timescale 1ns/1ps
module data_space_paging_agu_tb_top;
   import paging_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        req_valid, req_write, req_dual, req_update, req_pre, wreg_we;
   logic [3:0]  x_sel, y_sel, wreg_sel;
   logic [15:0] x_modify, y_modify, wreg_data, y_acc_addr, stack_pointer;
   logic        acc_valid, acc_write, y_acc_valid;
   target_t     acc_target;
   logic [23:0] acc_addr;
   int          errors = 0;
   int          total_checks = 0;

   always #25 aclk = ~aclk;

   data_space_paging_agu #(.DSP_EN(1'b1)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .req_valid, .req_write, .req_dual, .req_update, .req_pre, .x_sel, .y_sel,
      .x_modify, .y_modify, .wreg_we, .wreg_sel, .wreg_data, .acc_valid, .acc_write,
      .acc_target, .acc_addr, .y_acc_valid, .y_acc_addr, .stack_pointer);

   core_model core_u (
      .aclk, .req_valid, .req_write, .req_dual, .req_update, .req_pre, .x_sel,
      .y_sel, .x_modify, .y_modify, .wreg_we, .wreg_sel, .wreg_data);

   task automatic print_verdict();
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic lim(input int n);
      if (n >= 40) begin
         errors++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      lim(n);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      lim(n);
      s_axi_rready <= 1'b0;
      check("rdata", s_axi_rdata, ed);
      check("rresp", s_axi_rresp, er);
   endtask

   // one core access, then the registered answer one cycle later
   task automatic go(input logic w, dual, upd, pre, input logic [3:0] xs, ys,
                     input logic [15:0] xm, input target_t et, input logic [23:0] ea);
      core_u.access(w, dual, upd, pre, xs, ys, xm, 16'h0002);
      check("acc_valid", acc_valid, 1'b1);
      check("y_acc_valid", y_acc_valid, dual);
      check("acc_write", acc_write, w);
      check("acc_target", acc_target, et);
      check("acc_addr", acc_addr, ea);
   endtask

   task automatic t_regs();
      rd(8'h00, 32'h0, RESP_OKAY);
      rd(8'h10, 32'h0000FFFF, RESP_OKAY);
      rd(8'h24, 32'h0, RESP_SLVERR);
      wr(8'h26, 32'h1, RESP_SLVERR);
      wr(8'h00, 32'hFFFFFFFF, RESP_OKAY);
      rd(8'h00, 32'h000003FF, RESP_OKAY);
      wr(8'h04, 32'hFFFFFFFF, RESP_OKAY);
      rd(8'h04, 32'h000001FF, RESP_OKAY);
   endtask

   task automatic t_paging();
      core_u.set_wreg(4'h1, 16'h1234);
      go(1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0, 16'h0, TGT_BASE, 24'h001234);
      wr(8'h00, 32'h5, RESP_OKAY);
      core_u.set_wreg(4'h2, 16'h8ABC);
      go(1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 4'h0, 16'h0, TGT_EDS, 24'h028ABC);
      core_u.set_wreg(4'h3, 16'hFFFE);
      go(1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 4'h0, 16'h0, TGT_EDS, 24'hFFFFFE);
      wr(8'h00, 32'h203, RESP_OKAY);
      core_u.set_wreg(4'h4, 16'h8010);
      go(1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0, TGT_PSV, 24'h018010);
      go(1'b1, 1'b0, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0, TGT_EDS, 24'hFF8010);
      rd(8'h20, 32'h01FF8010, RESP_OKAY);
   endtask

   task automatic t_step();
      wr(8'h00, 32'h5, RESP_OKAY);
      core_u.set_wreg(4'h5, 16'hFFFE);
      go(1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 4'h0, 16'h2, TGT_EDS, 24'h02FFFE);
      go(1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 4'h0, 16'h0, TGT_EDS, 24'h030000);
      rd(8'h00, 32'h6, RESP_OKAY);
   endtask

   task automatic t_dsp();
      core_u.set_wreg(4'hA, 16'h1200);
      go(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'hA, 16'h0, TGT_BASE, 24'h001234);
      check("y_acc_addr", y_acc_addr, 16'h1200);
      wr(8'h0C, 32'h1000, RESP_OKAY);
      wr(8'h10, 32'h1007, RESP_OKAY);
      wr(8'h08, 32'h1, RESP_OKAY);
      core_u.set_wreg(4'h6, 16'h1006);
      go(1'b0, 1'b0, 1'b1, 1'b1, 4'h6, 4'h0, 16'h2, TGT_BASE, 24'h001000);
      go(1'b0, 1'b0, 1'b0, 1'b0, 4'h6, 4'h0, 16'h0, TGT_BASE, 24'h001000);
      wr(8'h1C, 32'h8, RESP_OKAY);
      wr(8'h08, 32'h4, RESP_OKAY);
      core_u.set_wreg(4'h7, 16'h0000);
      go(1'b0, 1'b0, 1'b1, 1'b0, 4'h7, 4'h0, 16'h2, TGT_BASE, 24'h000000);
      go(1'b0, 1'b0, 1'b1, 1'b0, 4'h7, 4'h0, 16'h2, TGT_BASE, 24'h000008);
      go(1'b0, 1'b0, 1'b1, 1'b0, 4'h7, 4'h0, 16'h2, TGT_BASE, 24'h000004);
      core_u.set_wreg(4'hF, 16'h0800);
      #1;
      check("stack_pointer", stack_pointer, 16'h0800);
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_paging();
      t_step();
      t_dsp();
      print_verdict();
   end
endmodule
